// file: logic/global_status_and_mode_regs.sv
`timescale 1ns/1ps
module global_status_and_mode_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host register port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // status sources
    input wire logic crystal_fail_flag,
    input wire logic power_on_event,
    input wire logic watchdog_event,
    input wire logic current_sequence_reversed,
    input wire logic voltage_sequence_reversed,
    input wire logic second_pulse_reverse,
    input wire logic first_pulse_reverse,
    // control outputs
    output logic external_clock_select,
    output logic firmware_restart,
    output logic signal_processing_disable,
    output logic ring_oscillator_mode,
    output logic ring_oscillator_active
);
    reg_port_if bus ();
    logic por_q;
    logic wdt_q;
    logic [7:0] ctrl_q;
    logic [7:0] rdata_q;
    logic [7:0] status_w;
    logic restart_done;
    logic restart_pulse;
    logic status_wr;
    logic ctrl_wr;

    // ==========================================
    // host port into the internal bundle
    assign bus.wr_en = host_wr;
    assign bus.rd_en = host_rd;
    assign bus.addr = host_addr;
    assign bus.wdata = host_wdata;
    assign host_rdata = rdata_q;
    assign bus.rdata = rdata_q;

    // address decode; virtual region and unmapped writes fall through
    always_comb begin
        status_wr = 1'b0;
        ctrl_wr = 1'b0;
        if (!bus.wr_en) begin
            status_wr = 1'b0;
        end else if (bus.addr == gsm_pkg::global_status_off) begin
            status_wr = 1'b1;
        end else if (bus.addr == gsm_pkg::operating_control_zero_off) begin
            ctrl_wr = 1'b1;
        end else if (bus.addr >= gsm_pkg::virtual_region_base) begin
            status_wr = 1'b0;
        end
    end

    // ==========================================
    // reset-cause flags: event set wins over host clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            por_q <= gsm_pkg::global_status_rst[gsm_pkg::power_on_reset_pos];
            wdt_q <= gsm_pkg::global_status_rst[gsm_pkg::watchdog_reset_pos];
        end else begin
            if (power_on_event || restart_done) begin
                por_q <= 1'b1;
            end else if (status_wr && !bus.wdata[gsm_pkg::power_on_reset_pos]) begin
                por_q <= 1'b0;
            end
            if (watchdog_event) begin
                wdt_q <= 1'b1;
            end else if (status_wr && !bus.wdata[gsm_pkg::watchdog_reset_pos]) begin
                wdt_q <= 1'b0;
            end
        end
    end

    // live status word, bit 7 reserved
    always_comb begin
        status_w = 8'h00;
        status_w[gsm_pkg::crystal_fail_pos] = crystal_fail_flag;
        status_w[gsm_pkg::power_on_reset_pos] = por_q;
        status_w[gsm_pkg::watchdog_reset_pos] = wdt_q;
        status_w[gsm_pkg::current_seq_pos] = current_sequence_reversed;
        status_w[gsm_pkg::voltage_seq_pos] = voltage_sequence_reversed;
        status_w[gsm_pkg::second_pulse_pos] = second_pulse_reverse;
        status_w[gsm_pkg::first_pulse_pos] = first_pulse_reverse;
    end

    // ==========================================
    // control register, reserved bits masked
    // a host write in the restart-done cycle keeps its other bits; only bit 3 is forced low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= gsm_pkg::operating_control_zero_rst;
        end else if (ctrl_wr) begin
            ctrl_q <= bus.wdata & gsm_pkg::control_write_mask;
            if (restart_done) begin
                ctrl_q[gsm_pkg::firmware_restart_pos] <= 1'b0;
            end
        end else if (restart_done) begin
            ctrl_q[gsm_pkg::firmware_restart_pos] <= 1'b0;
        end
    end

    // restart sequencing
    restart_seq u_restart (
        .clk(clk),
        .rst_n(rst_n),
        .start(ctrl_q[gsm_pkg::firmware_restart_pos] && !restart_pulse),
        .restart_pulse(restart_pulse),
        .done(restart_done)
    );

    // control outputs
    assign external_clock_select = ctrl_q[gsm_pkg::external_clock_pos];
    assign firmware_restart = restart_pulse;
    assign signal_processing_disable = ctrl_q[gsm_pkg::dsp_disable_pos];
    assign ring_oscillator_mode = ctrl_q[gsm_pkg::ring_osc_pos];
    assign ring_oscillator_active = ring_oscillator_mode || crystal_fail_flag;

    // ==========================================
    // registered read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (!bus.rd_en) begin
            rdata_q <= rdata_q;
        end else if (bus.addr == gsm_pkg::global_status_off) begin
            rdata_q <= status_w;
        end else if (bus.addr == gsm_pkg::operating_control_zero_off) begin
            rdata_q <= ctrl_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
endmodule

// file: logic/gsm_pkg.sv
package gsm_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] global_status_off = 8'h00;
    localparam logic [7:0] operating_control_zero_off = 8'h01;
    localparam logic [7:0] virtual_region_base = 8'h80;
    // ==========================================
    // status field positions
    localparam int crystal_fail_pos = 6;
    localparam int power_on_reset_pos = 5;
    localparam int watchdog_reset_pos = 4;
    localparam int current_seq_pos = 3;
    localparam int voltage_seq_pos = 2;
    localparam int second_pulse_pos = 1;
    localparam int first_pulse_pos = 0;
    // ==========================================
    // control field positions
    localparam int external_clock_pos = 4;
    localparam int firmware_restart_pos = 3;
    localparam int dsp_disable_pos = 2;
    localparam int ring_osc_pos = 1;
    // ==========================================
    // reset values and writable masks
    localparam logic [7:0] global_status_rst = 8'h00;
    localparam logic [7:0] operating_control_zero_rst = 8'h00;
    localparam logic [7:0] control_write_mask = 8'h1e;
    localparam logic [7:0] status_clear_mask = 8'h30;
    // ==========================================
    // restart pulse length in cycles
    localparam logic [3:0] restart_pulse_cycles = 4'h4;
    // ==========================================
    // restart sequencer states, gray from idle to pulse to clear; clear back to idle flips both bits
    typedef enum logic [1:0] {
        rs_idle = 2'b00,
        rs_pulse = 2'b01,
        rs_clear = 2'b11
    } restart_state_t;
endpackage

// file: logic/reg_port_if.sv
`timescale 1ns/1ps
// ==========================================
// internal register access bundle
interface reg_port_if;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output wr_en, rd_en, addr, wdata, input rdata);
    modport regs (input wr_en, rd_en, addr, wdata, output rdata);
endinterface

// file: logic/restart_seq.sv
`timescale 1ns/1ps
// ==========================================
// firmware restart sequencer
module restart_seq (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request and outputs
    input wire logic start,
    output logic restart_pulse,
    output logic done
);
    gsm_pkg::restart_state_t state_q;
    logic [3:0] cnt_q;

    // sequence: pulse for a fixed count then report done
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= gsm_pkg::rs_idle;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                gsm_pkg::rs_idle: begin
                    cnt_q <= 4'h0;
                    if (start) begin
                        state_q <= gsm_pkg::rs_pulse;
                    end
                end
                gsm_pkg::rs_pulse: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == gsm_pkg::restart_pulse_cycles - 4'h1) begin
                        state_q <= gsm_pkg::rs_clear;
                    end
                end
                default: begin
                    state_q <= gsm_pkg::rs_idle;
                end
            endcase
        end
    end

    // outputs decoded from state
    assign restart_pulse = (state_q == gsm_pkg::rs_pulse);
    assign done = (state_q == gsm_pkg::rs_clear);
endmodule

// file: tb/gsm_sva.sv
`timescale 1ns/1ps
// ==========================================
// port checker
module gsm_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    // status sources
    input wire logic crystal_fail_flag,
    input wire logic power_on_event,
    input wire logic current_sequence_reversed,
    input wire logic voltage_sequence_reversed,
    input wire logic second_pulse_reverse,
    input wire logic first_pulse_reverse,
    // control outputs
    input wire logic external_clock_select,
    input wire logic firmware_restart,
    input wire logic signal_processing_disable,
    input wire logic ring_oscillator_mode,
    input wire logic ring_oscillator_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic st_rd;
    logic [2:0] ctl;
    logic [3:0] seq;
    // status read strobe and grouped views
    assign st_rd = host_rd && host_addr == 8'h00;
    assign ctl = {external_clock_select, signal_processing_disable, ring_oscillator_mode};
    assign seq = {current_sequence_reversed, voltage_sequence_reversed,
        second_pulse_reverse, first_pulse_reverse};
    property p_crystal; st_rd |=> host_rdata[6] == $past(crystal_fail_flag); endproperty
    a_crystal: assert property (p_crystal) else $error("crystal bit wrong");
    property p_seq; st_rd |=> host_rdata[3:0] == $past(seq); endproperty
    a_seq: assert property (p_seq) else $error("live bits wrong");
    property p_ring; ring_oscillator_active == (ring_oscillator_mode | crystal_fail_flag);
    endproperty
    a_ring: assert property (p_ring) else $error("ring clock wrong");
    property p_rsv; host_rd |=> !host_rdata[7]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    sequence s_por; power_on_event ##1 !host_wr ##1 st_rd; endsequence
    property p_por; s_por |=> host_rdata[5]; endproperty
    a_por: assert property (p_por) else $error("power flag lost");
    property p_ctrl; host_wr && host_addr == 8'h01 |=>
        ctl == {$past(host_wdata[4]), $past(host_wdata[2]), $past(host_wdata[1])}; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control write lost");
    property p_ro; host_wr && host_addr[7] |=> $stable(ctl); endproperty
    a_ro: assert property (p_ro) else $error("virtual write took");
    property p_restart; host_wr && host_addr == 8'h01 && host_wdata[3] && !firmware_restart
        |=> ##1 firmware_restart [*4] ##1 !firmware_restart; endproperty
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    c_restart: cover property ($rose(firmware_restart));
    c_ro: cover property (host_wr && host_addr[7]);
    c_por: cover property (s_por);
endmodule
bind global_status_and_mode_regs gsm_sva u_sva (.*);

// file: tb/host_model.sv
`timescale 1ns/1ps
// ==========================================
// host controller model
module host_model (
    // clock
    input wire logic clk,
    // register port
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    // idle port at time zero
    initial begin
        {host_wr, host_rd, host_addr, host_wdata} = 18'h0_0000;
    end
    // one write, held to its taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {host_wr, host_addr, host_wdata} <= {1'b1, a, d};
        @(posedge clk);
        {host_wr, host_addr, host_wdata} <= {1'b0, ~a, ~d}; // released lines do not hold
    endtask
    // one read, data taken an edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {host_rd, host_addr} <= {1'b1, a};
        @(posedge clk);
        {host_rd, host_addr} <= {1'b0, ~a};
        @(posedge clk);
        d = host_rdata;
    endtask
endmodule

// file: tb/global_status_and_mode_regs_test.sv
`timescale 1ns/1ps
// ==========================================
// bench for the status and mode bank
module global_status_and_mode_regs_test;
    logic clk, rst_n, host_wr, host_rd, crystal_fail_flag, power_on_event, watchdog_event;
    logic current_sequence_reversed, voltage_sequence_reversed;
    logic second_pulse_reverse, first_pulse_reverse, external_clock_select, firmware_restart;
    logic signal_processing_disable, ring_oscillator_mode, ring_oscillator_active;
    logic [7:0] host_addr, host_wdata, host_rdata, v;
    int n_errors, comparisons, k;
    global_status_and_mode_regs u_dut (.*);
    host_model u_host (.*);
    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // live status bits and ring clock
    task automatic t_status();
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            crystal_fail_flag <= (k == 0);
            {current_sequence_reversed, voltage_sequence_reversed, second_pulse_reverse,
                first_pulse_reverse} <= (k == 0) ? 4'ha : 4'h5;
            u_host.rd(8'h00, v);
            chk(v, (k == 0) ? 8'h4a : 8'h05);
            chk({7'h00, ring_oscillator_active}, (k == 0) ? 8'h01 : 8'h00);
        end
        $display("t_status done");
    endtask
    // reset cause flags set and cleared
    task automatic t_flags();
        @(posedge clk);
        {power_on_event, watchdog_event} <= 2'h3;
        @(posedge clk);
        {power_on_event, watchdog_event} <= 2'h0;
        u_host.rd(8'h00, v);
        chk(v, 8'h35);
        u_host.wr(8'h00, 8'hff);
        u_host.rd(8'h00, v);
        chk(v, 8'h35);
        u_host.wr(8'h00, 8'h20);
        u_host.rd(8'h00, v);
        chk(v, 8'h25);
        u_host.wr(8'h00, 8'h00);
        u_host.rd(8'h00, v);
        chk(v, 8'h05);
        $display("t_flags done");
    endtask
    // control bits and refused virtual write
    task automatic t_ctrl();
        u_host.wr(8'h01, 8'hf7);
        u_host.rd(8'h01, v);
        chk(v, 8'h16);
        u_host.wr(8'h80, 8'h00);
        @(posedge clk);
        chk({5'h00, external_clock_select, signal_processing_disable,
            ring_oscillator_mode}, 8'h07);
        u_host.wr(8'h01, 8'h00);
        u_host.rd(8'h01, v);
        chk(v, 8'h00);
        $display("t_ctrl done");
    endtask
    // firmware restart pulse and self clear
    task automatic t_restart();
        u_host.wr(8'h01, 8'h08);
        for (k = 0; firmware_restart !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            if (k > 8) begin
                n_errors++;
                wrap_up();
            end
        end
        for (k = 0; firmware_restart === 1'b1 && k < 9; k++) begin
            @(posedge clk);
            #1;
        end
        chk(k[7:0], 8'h04);
        u_host.rd(8'h01, v);
        chk(v, 8'h00);
        u_host.rd(8'h00, v);
        chk(v, 8'h25);
        $display("t_restart done");
    endtask
    // main sequence
    initial begin
        {n_errors, comparisons} = '0;
        {rst_n, crystal_fail_flag, power_on_event, watchdog_event} = 4'h0;
        {current_sequence_reversed, voltage_sequence_reversed} = 2'h0;
        {second_pulse_reverse, first_pulse_reverse} = 2'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        u_host.rd(8'h01, v);
        chk(v, 8'h00);
        t_status();
        t_flags();
        t_ctrl();
        t_restart();
        wrap_up();
    end
endmodule
